// ==== mulx_cost.sv ====
`timescale 1ns/1ps
// counts out the cycle cost of one multiply-class instruction
module mulx_cost
	import mulx_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	mulx_cost_if.cost cif
);
	logic [MULX_CNT_W+MULX_WAIT_W+1:0] cnt_q;
	logic [MULX_CNT_W+MULX_WAIT_W+1:0] cost_d;
	logic busy_q;
	logic rej_q;
	logic [MULX_CNT_W+MULX_WAIT_W+1:0] n;
	logic [MULX_CNT_W+MULX_WAIT_W+1:0] p;
	logic refuse;
	// sized copies keep the cost arithmetic at the counter's width
	localparam int COST_W = MULX_CNT_W + MULX_WAIT_W + 2;
	localparam logic [COST_W-1:0] C_ONE = COST_W'(MULX_CYC_ONE);
	localparam logic [COST_W-1:0] C_TWO = COST_W'(MULX_CYC_TWO);

	assign n = {{(MULX_WAIT_W+2){1'b0}}, cif.reps};
	assign refuse = cif.reps != '0 && (cif.op == MULX_OP_MPY_SHORT ||
		cif.op == MULX_OP_MPY_LONG);
	assign p = cif.code_ext ? {{(MULX_CNT_W+2){1'b0}}, cif.pwait} : '0;

	always_comb begin
		cost_d = '0;
		unique case (cif.op)
			MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE: begin
				if (n == '0)
					cost_d = cif.both_same_sa ? C_TWO + C_ONE : C_TWO;
				else if (cif.both_same_sa)
					cost_d = (n << 1) + C_ONE;
				else
					cost_d = n + C_ONE;
			end
			MULX_OP_MPY, MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR, MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR: begin
				if (n == '0)
					cost_d = cif.same_sa ? C_TWO : C_ONE;
				else
					cost_d = cif.same_sa ? n + C_ONE : n;
			end
			MULX_OP_MPY_SHORT: cost_d = C_ONE + p;
			MULX_OP_MPY_LONG: cost_d = C_TWO + (p << 1);
			MULX_OP_MAR: cost_d = (n == '0) ? C_ONE : n;
			MULX_OP_NONE: cost_d = C_ONE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (cif.start && !busy_q && !refuse) begin
			cnt_q <= cost_d - 1'b1;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (cnt_q == '0)
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// immediates refuse the repeat mechanism
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			rej_q <= 1'b0;
		else
			rej_q <= cif.start && !busy_q && refuse;
	end

	assign cif.busy = busy_q;
	assign cif.last = busy_q && cnt_q == '0;
	assign cif.rejected = rej_q;
endmodule // mulx_cost

// ==== mulx_cost_if.sv ====
`timescale 1ns/1ps
interface mulx_cost_if;
	import mulx_pkg::*;
	logic start;
	mulx_op_e op;
	logic [MULX_CNT_W-1:0] reps;
	logic [MULX_WAIT_W-1:0] pwait;
	logic code_ext;
	logic same_sa;
	logic both_same_sa;
	logic busy;
	logic last;
	logic rejected;
	modport ctl (output start, op, reps, pwait, code_ext, same_sa,
		both_same_sa, input busy, last, rejected);
	modport cost (input start, op, reps, pwait, code_ext, same_sa,
		both_same_sa, output busy, last, rejected);
endinterface

// ==== mulx_exec.sv ====
`timescale 1ns/1ps
module mulx_exec
	import mulx_pkg::*;
#(
	parameter int DATA_W = MULX_DATA_W,
	parameter int ACC_W = MULX_ACC_W
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// instruction issue
	input wire logic start_i,
	input wire mulx_op_e op_i,
	input wire logic [MULX_CNT_W-1:0] reps_i,
	input wire logic [MULX_WAIT_W-1:0] pwait_i,
	input wire logic code_ext_i,
	input wire logic same_sa_i,
	input wire logic both_same_sa_i,
	// operands
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [DATA_W-1:0] coef_i,
	input wire logic [DATA_W-1:0] imm_i,
	input wire logic post_inc_i,
	input wire logic next_arp_en_i,
	input wire logic [MULX_ARP_W-1:0] next_arp_i,
	// multiplier operand load
	input wire logic t0_load_i,
	input wire logic [DATA_W-1:0] t0_data_i,
	input wire logic compat_bit_i,
	input wire logic [MULX_SHIFT_W-1:0] pm_i,
	// results
	output logic busy_o,
	output logic done_o,
	output logic rejected_o,
	output logic [ACC_W-1:0] acc_o,
	output logic [ACC_W-1:0] prod_o,
	output logic [DATA_W-1:0] t0_o,
	output logic [MULX_T1_W-1:0] t1_o,
	output logic [MULX_T2_W-1:0] t2_o,
	output logic [MULX_ARP_W-1:0] arp_o,
	output logic [MULX_ARP_W-1:0] arb_o,
	output logic [DATA_W-1:0] ar_cur_o
);
	if (ACC_W != 2 * DATA_W || DATA_W <= MULX_SHORT_W) begin : g_bad_width
		$error("mulx_exec: unsupported data or accumulator width");
	end

	typedef enum logic [1:0] {
		MULX_ST_IDLE = 2'b01,
		MULX_ST_RUN = 2'b10
	} mulx_st_e;

	mulx_cost_if cif();
	mulx_cost u_cost (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.cif(cif)
	);

	mulx_st_e st_q;
	mulx_op_e op_q;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] prod_q;
	logic [DATA_W-1:0] t0_q;
	logic [MULX_T1_W-1:0] t1_q;
	logic [MULX_T2_W-1:0] t2_q;
	logic [MULX_ARP_W-1:0] arp_q;
	logic [MULX_ARP_W-1:0] arb_q;
	logic [DATA_W-1:0] ar_q [MULX_AR_NUM];
	logic done_q;
	logic step;
	logic [DATA_W-1:0] opnd;
	logic [ACC_W-1:0] prod_new;
	logic [ACC_W-1:0] prod_shf;
	logic is_imm;

	assign is_imm = op_i == MULX_OP_MPY_SHORT || op_i == MULX_OP_MPY_LONG;
	assign cif.start = start_i && st_q == MULX_ST_IDLE;
	assign cif.op = op_i;
	assign cif.reps = reps_i;
	assign cif.pwait = pwait_i;
	assign cif.code_ext = code_ext_i;
	assign cif.same_sa = same_sa_i;
	assign cif.both_same_sa = both_same_sa_i;

	// results are applied once at issue; the counter models occupancy
	// a repeated immediate reaches the cost block only to be refused there
	assign step = cif.start && !(is_imm && reps_i != '0);

	always_comb begin
		opnd = data_i;
		if (op_i == MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE)
			opnd = coef_i;
		else if (op_i == MULX_OP_MPY_SHORT)
			opnd = {{(DATA_W-MULX_SHORT_W){imm_i[MULX_SHORT_W-1]}},
				imm_i[MULX_SHORT_W-1:0]};
		else if (op_i == MULX_OP_MPY_LONG)
			opnd = imm_i;
	end

	assign prod_new = $signed(op_i == MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE ? data_i : t0_q) *
		$signed(opnd);

	always_comb begin
		prod_shf = prod_q;
		unique case (pm_i)
			2'h0: prod_shf = prod_q;
			2'h1: prod_shf = prod_q << 1;
			2'h2: prod_shf = prod_q << 4;
			2'h3: prod_shf = ACC_W'($signed(prod_q) >>> 6);
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			st_q <= MULX_ST_IDLE;
		else if (step)
			st_q <= MULX_ST_RUN;
		else if (st_q == MULX_ST_RUN && cif.last)
			st_q <= MULX_ST_IDLE;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			op_q <= MULX_OP_NONE;
		else if (step)
			op_q <= op_i;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			done_q <= 1'b0;
		else
			done_q <= st_q == MULX_ST_RUN && cif.last;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			acc_q <= MULX_ACC_RST;
			prod_q <= '0;
		end else if (step && op_i != MULX_OP_MAR && op_i != MULX_OP_NONE) begin
			prod_q <= prod_new;
			if (op_i == MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR || op_i == MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE)
				acc_q <= acc_q + prod_shf;
			else if (op_i == MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR)
				acc_q <= acc_q - prod_shf;
		end
	end

	// table multiply loads the data word into the operand register
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			t0_q <= MULX_T0_RST;
			t1_q <= '0;
			t2_q <= '0;
		end else if (t0_load_i || (step && op_i == MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE)) begin
			t0_q <= t0_load_i ? t0_data_i : data_i;
			if (!compat_bit_i) begin
				t1_q <= t0_load_i ? t0_data_i[MULX_T1_W-1:0] :
					data_i[MULX_T1_W-1:0];
				t2_q <= t0_load_i ? t0_data_i[MULX_T2_W-1:0] :
					data_i[MULX_T2_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			arp_q <= MULX_ARP_RST;
			arb_q <= MULX_ARP_RST;
		end else if (step && next_arp_en_i) begin
			arb_q <= arp_q;
			arp_q <= next_arp_i;
		end
	end

	generate
		for (genvar i = 0; i < MULX_AR_NUM; i++) begin : g_ar
			always_ff @(posedge mclk_i) begin
				if (srst_i)
					ar_q[i] <= '0;
				else if (step && post_inc_i && arp_q == MULX_ARP_W'(i))
					ar_q[i] <= ar_q[i] + 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rejected_o <= 1'b0;
			ar_cur_o <= '0;
		end else begin
			busy_o <= cif.busy;
			done_o <= done_q;
			rejected_o <= cif.rejected;
			ar_cur_o <= ar_q[arp_q];
		end
	end

	assign acc_o = acc_q;
	assign prod_o = prod_q;
	assign t0_o = t0_q;
	assign t1_o = t1_q;
	assign t2_o = t2_q;
	assign arp_o = arp_q;
	assign arb_o = arb_q;

	sequence s_issue_imm_rep;
		start_i && is_imm && reps_i != '0 && st_q == MULX_ST_IDLE;
	endsequence

	property p_coefficient_table_multiply_accumulate_cost;
		@(posedge mclk_i) disable iff (srst_i)
		cif.start && op_i == MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE && both_same_sa_i && reps_i == 8'h3
		|=> cif.busy [*7] ##1 !cif.busy;
	endproperty
	a_coefficient_table_multiply_accumulate_cost: assert property (p_coefficient_table_multiply_accumulate_cost)
		else $error("table multiply cost wrong");

	property p_mpy_single;
		@(posedge mclk_i) disable iff (srst_i)
		cif.start && op_i == MULX_OP_MPY && !same_sa_i && reps_i == '0
		|=> cif.busy ##1 !cif.busy;
	endproperty
	a_mpy_single: assert property (p_mpy_single)
		else $error("plain multiply not one cycle");

	property p_mpy_shared;
		@(posedge mclk_i) disable iff (srst_i)
		cif.start && op_i == MULX_OP_MPY && same_sa_i && reps_i == '0
		|=> cif.busy [*2] ##1 !cif.busy;
	endproperty
	a_mpy_shared: assert property (p_mpy_shared)
		else $error("shared block multiply not two cycles");

	property p_imm_norep;
		@(posedge mclk_i) disable iff (srst_i)
		s_issue_imm_rep |=> !cif.busy ##1 rejected_o;
	endproperty
	a_imm_norep: assert property (p_imm_norep)
		else $error("immediate multiply accepted under repeat");

	property p_long_cost;
		@(posedge mclk_i) disable iff (srst_i)
		step && op_i == MULX_OP_MPY_LONG && code_ext_i && pwait_i == 4'h3
		|=> cif.busy [*8] ##1 !cif.busy;
	endproperty
	a_long_cost: assert property (p_long_cost)
		else $error("long immediate cost wrong");

	property p_short_cost;
		@(posedge mclk_i) disable iff (srst_i)
		step && op_i == MULX_OP_MPY_SHORT && !code_ext_i
		|=> cif.busy ##1 !cif.busy;
	endproperty
	a_short_cost: assert property (p_short_cost)
		else $error("short immediate cost wrong");

	property p_mar_ptr;
		@(posedge mclk_i) disable iff (srst_i)
		step && next_arp_en_i |=> arp_q == $past(next_arp_i)
			&& arb_q == $past(arp_q);
	endproperty
	a_mar_ptr: assert property (p_mar_ptr)
		else $error("pointer not loaded");

	property p_mar_inc;
		@(posedge mclk_i) disable iff (srst_i)
		step && post_inc_i |=> ar_q[$past(arp_q)] == $past(ar_q[arp_q]) + 1'b1;
	endproperty
	a_mar_inc: assert property (p_mar_inc)
		else $error("current register not incremented");

	property p_compat;
		@(posedge mclk_i) disable iff (srst_i)
		t0_load_i && !compat_bit_i |=> t1_q == t0_q[MULX_T1_W-1:0]
			&& t2_q == t0_q[MULX_T2_W-1:0];
	endproperty
	a_compat: assert property (p_compat)
		else $error("temps not copied");

	property p_multiply_subtract_previous_instr;
		@(posedge mclk_i) disable iff (srst_i)
		step && op_i == MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR |=> acc_q == $past(acc_q) - $past(prod_shf)
			&& prod_q == $past(prod_new);
	endproperty
	a_multiply_subtract_previous_instr: assert property (p_multiply_subtract_previous_instr)
		else $error("subtract form wrong");
endmodule // mulx_exec

// ==== mulx_exec_bench.sv ====
`timescale 1ns/1ps
module mulx_exec_bench;
	import mulx_pkg::*;
	logic mclk_i, srst_i, start_i, code_ext_i, same_sa_i, both_same_sa_i;
	logic post_inc_i, next_arp_en_i, t0_load_i, compat_bit_i;
	mulx_op_e op_i;
	logic [7:0] reps_i;
	logic [3:0] pwait_i, t2_o;
	logic [2:0] next_arp_i, arp_o, arb_o;
	logic [1:0] pm_i;
	logic [15:0] data_i, coef_i, imm_i, t0_data_i, t0_o, ar_cur_o;
	logic busy_o, done_o, rejected_o, rej;
	logic [31:0] acc_o, prod_o;
	logic [4:0] t1_o;
	int errors = 0;
	int checks_done = 0;
	int cyc;

	mulx_exec dut (.mclk_i, .srst_i, .start_i, .op_i, .reps_i, .pwait_i,
		.code_ext_i, .same_sa_i, .both_same_sa_i, .data_i, .coef_i,
		.imm_i, .post_inc_i, .next_arp_en_i, .next_arp_i, .t0_load_i,
		.t0_data_i, .compat_bit_i, .pm_i, .busy_o, .done_o, .rejected_o,
		.acc_o, .prod_o, .t0_o, .t1_o, .t2_o, .arp_o, .arb_o, .ar_cur_o);

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask

	// fl packs code external, same block, both operands in same block
	task automatic issue(input mulx_op_e op, input logic [7:0] n,
		input logic [3:0] p, input logic [2:0] fl, input logic [15:0] d);
		int i;
		bit fin;
		cyc = 0;
		fin = 0;
		rej = 0;
		@(posedge mclk_i);
		start_i <= 1'b1;
		op_i <= op;
		reps_i <= n;
		pwait_i <= p;
		{code_ext_i, same_sa_i, both_same_sa_i} <= fl;
		data_i <= d;
		imm_i <= d;
		@(posedge mclk_i);
		start_i <= 1'b0;
		// cost is the number of cycles busy stands high, lag ignored
		for (i = 0; i < 300; i++) begin
			@(posedge mclk_i);
			#1;
			if (busy_o === 1'b1) cyc++;
			if (rejected_o === 1'b1) rej = 1;
			if (done_o === 1'b1 || rej) fin = 1;
			if (fin && busy_o !== 1'b1) break;
		end
		if (i == 300) begin
			errors++;
			wrap_up();
		end
		tick(2);
	endtask

	task automatic load_t0(input logic [15:0] v, input logic cb);
		@(posedge mclk_i);
		t0_load_i <= 1'b1;
		t0_data_i <= v;
		compat_bit_i <= cb;
		@(posedge mclk_i);
		t0_load_i <= 1'b0;
		tick(2);
	endtask

	task automatic t_reset();
		chk("prod", 32'h0, prod_o);
		chk("acc", 32'h0, acc_o);
		chk("busy", 32'h0, 32'(busy_o));
	endtask

	// temps keep their width, so only the low bits follow
	task automatic t_compat();
		load_t0(16'h001e, 1'b0);
		chk("t0", 32'h1e, 32'(t0_o));
		chk("t1", 32'h1e, 32'(t1_o));
		chk("t2", 32'he, 32'(t2_o));
		load_t0(16'h0006, 1'b1);
		chk("t0", 32'h6, 32'(t0_o));
		chk("t1 kept", 32'h1e, 32'(t1_o));
	endtask

	task automatic t_plain();
		issue(MULX_OP_MPY, 8'h0, 4'h0, 3'b000, 16'h7);
		chk("mpy cyc", 32'd1, 32'(cyc));
		chk("mpy prod", 32'h2a, prod_o);
		issue(MULX_OP_MPY, 8'h0, 4'h0, 3'b010, 16'h7);
		chk("mpy same cyc", 32'd2, 32'(cyc));
		issue(MULX_OP_MPY, 8'h4, 4'h0, 3'b010, 16'h7);
		chk("mpy rpt cyc", 32'd5, 32'(cyc));
	endtask

	task automatic t_accum();
		issue(MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR, 8'h0, 4'h0, 3'b000, 16'h3);
		chk("multiply_add_previous_instr acc", 32'h2a, acc_o);
		chk("multiply_add_previous_instr prod", 32'h12, prod_o);
		issue(MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR, 8'h0, 4'h0, 3'b000, 16'h7);
		chk("multiply_subtract_previous_instr acc", 32'h18, acc_o);
		chk("multiply_subtract_previous_instr prod", 32'h2a, prod_o);
	endtask

	task automatic t_imm();
		load_t0(16'h0002, 1'b1);
		issue(MULX_OP_MPY_SHORT, 8'h0, 4'h3, 3'b100, 16'h31);
		chk("short ext cyc", 32'd4, 32'(cyc));
		chk("short prod", 32'h62, prod_o);
		issue(MULX_OP_MPY_SHORT, 8'h0, 4'h3, 3'b000, 16'h31);
		chk("short cyc", 32'd1, 32'(cyc));
		issue(MULX_OP_MPY_LONG, 8'h0, 4'h3, 3'b100, 16'h1234);
		chk("long ext cyc", 32'd8, 32'(cyc));
		chk("long prod", 32'h2468, prod_o);
		issue(MULX_OP_MPY_LONG, 8'h0, 4'h3, 3'b000, 16'h1234);
		chk("long cyc", 32'd2, 32'(cyc));
		issue(MULX_OP_MPY_SHORT, 8'h2, 4'h0, 3'b000, 16'h5);
		chk("short rpt refused", 32'd1, 32'(rej));
		chk("short rpt cyc", 32'd0, 32'(cyc));
		issue(MULX_OP_MPY_LONG, 8'h1, 4'h0, 3'b000, 16'h5);
		chk("long rpt refused", 32'd1, 32'(rej));
		chk("long rpt prod", 32'h2468, prod_o);
	endtask

	task automatic t_table();
		load_t0(16'h004e, 1'b1);
		issue(MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE, 8'h3, 4'h0, 3'b001, 16'h8);
		chk("coefficient_table_multiply_accumulate cyc", 32'd7, 32'(cyc));
		chk("coefficient_table_multiply_accumulate prod", 32'h10, prod_o);
		chk("coefficient_table_multiply_accumulate acc", 32'h2480, acc_o);
		chk("coefficient_table_multiply_accumulate t0", 32'h8, 32'(t0_o));
	endtask

	// product shift modes, the last one on a negative product
	task automatic t_shift();
		@(posedge mclk_i);
		pm_i <= 2'h1;
		issue(MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR, 8'h0, 4'h0, 3'b000, 16'h1);
		chk("pm1 acc", 32'h24a0, acc_o);
		chk("pm1 prod", 32'h8, prod_o);
		@(posedge mclk_i);
		pm_i <= 2'h2;
		issue(MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR, 8'h0, 4'h0, 3'b000, 16'h0);
		chk("pm2 acc", 32'h2420, acc_o);
		issue(MULX_OP_MPY, 8'h0, 4'h0, 3'b000, 16'hffff);
		chk("neg prod", 32'hfffffff8, prod_o);
		@(posedge mclk_i);
		pm_i <= 2'h3;
		issue(MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR, 8'h0, 4'h0, 3'b000, 16'h0);
		chk("pm3 acc", 32'h241f, acc_o);
	endtask

	task automatic t_modify();
		@(posedge mclk_i);
		next_arp_en_i <= 1'b1;
		next_arp_i <= 3'h1;
		issue(MULX_OP_MAR, 8'h0, 4'h0, 3'b000, 16'h0);
		chk("ar1 before", 32'h0, 32'(ar_cur_o));
		@(posedge mclk_i);
		post_inc_i <= 1'b1;
		next_arp_i <= 3'h5;
		issue(MULX_OP_MAR, 8'h0, 4'h0, 3'b000, 16'h0);
		chk("arp", 32'h5, 32'(arp_o));
		chk("arb", 32'h1, 32'(arb_o));
		@(posedge mclk_i);
		post_inc_i <= 1'b0;
		next_arp_i <= 3'h1;
		issue(MULX_OP_MAR, 8'h0, 4'h0, 3'b000, 16'h0);
		chk("ar1 inc", 32'h1, 32'(ar_cur_o));
	endtask

	initial begin
		srst_i = 1'b1;
		{start_i, code_ext_i, same_sa_i, both_same_sa_i} = 4'h0;
		{post_inc_i, next_arp_en_i, t0_load_i, compat_bit_i} = 4'h1;
		op_i = MULX_OP_NONE;
		{reps_i, pwait_i, next_arp_i, pm_i} = 17'h0;
		{data_i, imm_i, t0_data_i} = 48'h0;
		coef_i = 16'h0002;
		repeat (12) @(posedge mclk_i);
		srst_i <= 1'b0;
		tick(1);
		t_reset();
		t_compat();
		t_plain();
		t_accum();
		t_imm();
		t_table();
		t_shift();
		t_modify();
		wrap_up();
	end
endmodule // mulx_exec_bench

// ==== mulx_pkg.sv ====
package mulx_pkg;
	// operation codes presented by the decode stage
	typedef enum logic [2:0] {
		MULX_OP_NONE = 3'h0,
		MULX_OP_MPY = 3'h1,
		MULX_OP_MPY_SHORT = 3'h2,
		MULX_OP_MPY_LONG = 3'h3,
		MULX_OP_MULTIPLY_ADD_PREVIOUS_INSTR = 3'h4,
		MULX_OP_MULTIPLY_SUBTRACT_PREVIOUS_INSTR = 3'h5,
		MULX_OP_COEFFICIENT_TABLE_MULTIPLY_ACCUMULATE = 3'h6,
		MULX_OP_MAR = 3'h7
	} mulx_op_e;
	localparam int MULX_DATA_W = 16;
	localparam int MULX_ACC_W = 32;
	localparam int MULX_T1_W = 5;
	localparam int MULX_T2_W = 4;
	localparam int MULX_AR_NUM = 8;
	localparam int MULX_ARP_W = 3;
	localparam int MULX_CNT_W = 8;
	localparam int MULX_WAIT_W = 4;
	localparam int MULX_SHORT_W = 13;
	localparam int MULX_SHIFT_W = 2;
	localparam logic [MULX_ACC_W-1:0] MULX_ACC_RST = 32'h0;
	localparam logic [MULX_DATA_W-1:0] MULX_T0_RST = 16'h0;
	localparam logic [MULX_ARP_W-1:0] MULX_ARP_RST = 3'h0;
	// base cycle figures
	localparam int MULX_CYC_ONE = 1;
	localparam int MULX_CYC_TWO = 2;
endpackage
